// [verilog/sgp_map.vh]
// Register map, field positions and reset values of the shared port block.
// Included by every design file of the block; holds definitions only.
`ifndef SGP_MAP_VH
`define SGP_MAP_VH

// -----------------------------------------------------------------
// Register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define SGP_IDX_W 10
`define SGP_IDX_PE_DATA 10'h008
`define SGP_IDX_PF_DATA 10'h009
`define SGP_IDX_PG_DATA 10'h00a
`define SGP_IDX_PE_DIR 10'h00c
`define SGP_IDX_PF_DIR 10'h00d
`define SGP_IDX_PG_DIR 10'h00e
`define SGP_IDX_FUNC 10'h010
`define SGP_IDX_OWNED 10'h011

// -----------------------------------------------------------------
// Pin function control fields
// -----------------------------------------------------------------
`define SGP_FN_W 23
`define SGP_FN_SPI_EN 0
`define SGP_FN_SPI_MST 1
`define SGP_FN_SCI_EN 2
`define SGP_FN_ELS_E_LO 4
`define SGP_FN_ELS_F_LO 8
`define SGP_FN_KBD_LO 20

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define SGP_RST_PE_DIR 8'h00
`define SGP_RST_PF_DIR 7'h00
`define SGP_RST_PG_DIR 3'h0
`define SGP_RST_FUNC 23'h000000

// -----------------------------------------------------------------
// Bus responses
// -----------------------------------------------------------------
`define SGP_RESP_OKAY 2'h0
`define SGP_RESP_SLVERR 2'h2

`endif

// [verilog/sgp_axil_slave.v]
// AXI4-Lite slave front end of the shared port block.
// Assumes the register file answers hits and read data combinationally.
`timescale 1ns/1ps
`default_nettype none
`include "sgp_map.vh"

module sgp_axil_slave #(
	parameter ADDR_W = 12
) (
	input wire core_clk_i,
	input wire sys_rst_i,
	input wire [ADDR_W-1:0] s_axi_awaddr_i,
	input wire s_axi_awvalid_i,
	output wire s_axi_awready_o,
	input wire [31:0] s_axi_wdata_i,
	input wire [3:0] s_axi_wstrb_i,
	input wire s_axi_wvalid_i,
	output wire s_axi_wready_o,
	output wire [1:0] s_axi_bresp_o,
	output wire s_axi_bvalid_o,
	input wire s_axi_bready_i,
	input wire [ADDR_W-1:0] s_axi_araddr_i,
	input wire s_axi_arvalid_i,
	output wire s_axi_arready_o,
	output wire [31:0] s_axi_rdata_o,
	output wire [1:0] s_axi_rresp_o,
	output wire s_axi_rvalid_o,
	input wire s_axi_rready_i,
	output wire wr_en_o,
	output wire [`SGP_IDX_W-1:0] wr_idx_o,
	output wire [31:0] wr_data_o,
	output wire [3:0] wr_strb_o,
	input wire wr_hit_i,
	output wire [`SGP_IDX_W-1:0] rd_idx_o,
	input wire [31:0] rd_data_i,
	input wire rd_hit_i
);

	// Captured write address and data, either may arrive first
	reg aw_have_q;
	reg w_have_q;
	reg [`SGP_IDX_W-1:0] aw_idx_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg bvalid_q;
	reg [1:0] bresp_q;
	reg rvalid_q;
	reg [1:0] rresp_q;
	reg [31:0] rdata_q;

	// -----------------------------------------------------------------
	// Write channel
	// -----------------------------------------------------------------
	assign s_axi_awready_o = ~aw_have_q & ~bvalid_q;
	assign s_axi_wready_o = ~w_have_q & ~bvalid_q;
	assign wr_en_o = aw_have_q & w_have_q & ~bvalid_q;
	assign wr_idx_o = aw_idx_q;
	assign wr_data_o = w_data_q;
	assign wr_strb_o = w_strb_q;
	assign s_axi_bvalid_o = bvalid_q;
	assign s_axi_bresp_o = bresp_q;

	// Capture, commit, then hold the response until taken
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_idx_q <= {`SGP_IDX_W{1'b0}};
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= `SGP_RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_have_q <= 1'b1;
				aw_idx_q <= s_axi_awaddr_i[`SGP_IDX_W+1:2];
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata_i;
				w_strb_q <= s_axi_wstrb_i;
			end
			if (wr_en_o) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit_i ? `SGP_RESP_OKAY : `SGP_RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready_i) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// -----------------------------------------------------------------
	// Read channel: data sampled at the address handshake
	// -----------------------------------------------------------------
	assign s_axi_arready_o = ~rvalid_q;
	assign rd_idx_o = s_axi_araddr_i[`SGP_IDX_W+1:2];
	assign s_axi_rvalid_o = rvalid_q;
	assign s_axi_rresp_o = rresp_q;
	assign s_axi_rdata_o = rdata_q;

	// One read outstanding at a time
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			rvalid_q <= 1'b0;
			rresp_q <= `SGP_RESP_OKAY;
			rdata_q <= 32'h00000000;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			rvalid_q <= 1'b1;
			rresp_q <= rd_hit_i ? `SGP_RESP_OKAY : `SGP_RESP_SLVERR;
			rdata_q <= rd_hit_i ? rd_data_i : 32'h00000000;
		end else if (rvalid_q && s_axi_rready_i) begin
			rvalid_q <= 1'b0;
		end
	end

	// Low address bits below the index are ignored on purpose
	wire unused_addr = &{1'b0, s_axi_awaddr_i[1:0], s_axi_araddr_i[1:0]};

endmodule // sgp_axil_slave

`default_nettype wire

// [verilog/sgp_ports.v]
// Shared general-purpose ports E (8 pins), F (7 pins) and G (3 pins).
// Assumes SPI, SCI, timer and keypad logic on the same clock; pins async.
//
// Operation
// - Eight port E latches, one byte register
// - Direction one drives latch, zero floats pin
// - Reset clears all port E direction bits
// - Port E read gives latch where output
// - Port E read gives pin where input
// - Data writes always update latches only
// - Port F read mixes latch and pin
// - Reset clears all port F direction bits
// - Reset leaves port F latches unchanged
// - Port G latches kept; own direction bits
// - SPI enable claims port E pins 7-5
// - Pin 4 is slave select in slave
// - Claimed E pins: direction only steers reads
// - SCI enable claims port E pins 1-0
// - Timer channel fields claim E pins 3-2
// - Timer channel fields claim F pins 5-0
// - Claimed F pins: direction only steers reads
// - Keypad enables make G pins interrupt inputs
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "sgp_map.vh"

module sgp_ports #(
	parameter AXI_ADDR_W = 12
) (
	input wire core_clk_i,
	input wire sys_rst_i,
	// AXI4-Lite register bus
	input wire [AXI_ADDR_W-1:0] s_axi_awaddr_i,
	input wire s_axi_awvalid_i,
	output wire s_axi_awready_o,
	input wire [31:0] s_axi_wdata_i,
	input wire [3:0] s_axi_wstrb_i,
	input wire s_axi_wvalid_i,
	output wire s_axi_wready_o,
	output wire [1:0] s_axi_bresp_o,
	output wire s_axi_bvalid_o,
	input wire s_axi_bready_i,
	input wire [AXI_ADDR_W-1:0] s_axi_araddr_i,
	input wire s_axi_arvalid_i,
	output wire s_axi_arready_o,
	output wire [31:0] s_axi_rdata_o,
	output wire [1:0] s_axi_rresp_o,
	output wire s_axi_rvalid_o,
	input wire s_axi_rready_i,
	// Port pins, split into level, value and enable
	input wire [7:0] pe_pin_i,
	output wire [7:0] pe_pin_o,
	output wire [7:0] pe_pin_oe_o,
	input wire [6:0] pf_pin_i,
	output wire [6:0] pf_pin_o,
	output wire [6:0] pf_pin_oe_o,
	input wire [2:0] pg_pin_i,
	output wire [2:0] pg_pin_o,
	output wire [2:0] pg_pin_oe_o,
	// Drive requests from the sharing peripherals
	input wire [7:0] pe_alt_out_i,
	input wire [7:0] pe_alt_oe_i,
	input wire [5:0] pf_alt_out_i,
	input wire [5:0] pf_alt_oe_i,
	// Synchronised levels toward the peripherals
	output wire [7:0] pe_level_o,
	output wire [6:0] pf_level_o,
	output wire [2:0] keypad_input_pin_o,
	// Pin function enables toward the peripherals
	output wire spi_enable_bit_o,
	output wire spi_master_select_bit_o,
	output wire sci_enable_bit_o,
	output wire [2:0] keypad_interrupt_enable_bits_o
);

	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------

	// A timer channel claims its pin once its select field is nonzero
	function field_on;
		input [1:0] f;
		begin
			field_on = |f;
		end
	endfunction

	// Per bit: latch where direction is one, pin level where zero
	function [7:0] read_mix;
		input [7:0] dir;
		input [7:0] latch;
		input [7:0] pin;
		begin
			read_mix = (dir & latch) | (~dir & pin);
		end
	endfunction

	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	reg [7:0] pe_latch_q; // port_e_pin_latch, no reset
	reg [6:0] pf_latch_q; // port_f_pin_latch, no reset
	reg [2:0] pg_latch_q; // port_g_pin_latch, no reset
	reg [7:0] pe_dir_q; // port_e_direction
	reg [6:0] pf_dir_q; // port_f_direction
	reg [2:0] pg_dir_q; // port_g_direction
	reg [`SGP_FN_W-1:0] func_q; // pin function control
	reg [7:0] pe_meta_q; // first sync stage, read by second only
	reg [7:0] pe_sync_q;
	reg [6:0] pf_meta_q;
	reg [6:0] pf_sync_q;
	reg [2:0] pg_meta_q;
	reg [2:0] pg_sync_q;
	reg [7:0] pe_out_q; // registered pin drive
	reg [7:0] pe_oe_q;
	reg [6:0] pf_out_q;
	reg [6:0] pf_oe_q;
	reg [2:0] pg_out_q;
	reg [2:0] pg_oe_q;

	// Bus side wiring
	wire wr_en;
	wire [`SGP_IDX_W-1:0] wr_idx;
	wire [31:0] wr_data;
	wire [3:0] wr_strb;
	reg wr_hit;
	wire [`SGP_IDX_W-1:0] rd_idx;
	reg [31:0] rd_data;
	reg rd_hit;

	// Ownership and next drive values
	wire spi_en;
	wire spi_mst;
	wire sci_en;
	wire [2:0] kbd_en;
	wire [7:0] pe_owned;
	wire [6:0] pf_owned;
	wire [7:0] pe_alt_oe_eff;
	reg [7:0] pe_out_d;
	reg [7:0] pe_oe_d;
	reg [6:0] pf_out_d;
	reg [6:0] pf_oe_d;
	reg [2:0] pg_out_d;
	reg [2:0] pg_oe_d;

	// -----------------------------------------------------------------
	// Bus slave
	// -----------------------------------------------------------------
	sgp_axil_slave #(
		.ADDR_W(AXI_ADDR_W)
	) u_bus (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.s_axi_awaddr_i(s_axi_awaddr_i),
		.s_axi_awvalid_i(s_axi_awvalid_i),
		.s_axi_awready_o(s_axi_awready_o),
		.s_axi_wdata_i(s_axi_wdata_i),
		.s_axi_wstrb_i(s_axi_wstrb_i),
		.s_axi_wvalid_i(s_axi_wvalid_i),
		.s_axi_wready_o(s_axi_wready_o),
		.s_axi_bresp_o(s_axi_bresp_o),
		.s_axi_bvalid_o(s_axi_bvalid_o),
		.s_axi_bready_i(s_axi_bready_i),
		.s_axi_araddr_i(s_axi_araddr_i),
		.s_axi_arvalid_i(s_axi_arvalid_i),
		.s_axi_arready_o(s_axi_arready_o),
		.s_axi_rdata_o(s_axi_rdata_o),
		.s_axi_rresp_o(s_axi_rresp_o),
		.s_axi_rvalid_o(s_axi_rvalid_o),
		.s_axi_rready_i(s_axi_rready_i),
		.wr_en_o(wr_en),
		.wr_idx_o(wr_idx),
		.wr_data_o(wr_data),
		.wr_strb_o(wr_strb),
		.wr_hit_i(wr_hit),
		.rd_idx_o(rd_idx),
		.rd_data_i(rd_data),
		.rd_hit_i(rd_hit)
	);

	// -----------------------------------------------------------------
	// Pin synchronisers
	// -----------------------------------------------------------------

	// Two stages; pins are asynchronous to the core clock
	always @(posedge core_clk_i) begin
		pe_meta_q <= pe_pin_i;
		pe_sync_q <= pe_meta_q;
		pf_meta_q <= pf_pin_i;
		pf_sync_q <= pf_meta_q;
		pg_meta_q <= pg_pin_i;
		pg_sync_q <= pg_meta_q;
	end

	// -----------------------------------------------------------------
	// Data latches
	// -----------------------------------------------------------------

	// No reset: latch contents survive reset untouched
	always @(posedge core_clk_i) begin
		if (wr_en && wr_strb[0]) begin
			// Direction never blocks a latch write
			if (wr_idx == `SGP_IDX_PE_DATA) begin
				pe_latch_q <= wr_data[7:0];
			end
			if (wr_idx == `SGP_IDX_PF_DATA) begin
				pf_latch_q <= wr_data[6:0];
			end
			if (wr_idx == `SGP_IDX_PG_DATA) begin
				pg_latch_q <= wr_data[2:0];
			end
		end
	end

	// -----------------------------------------------------------------
	// Direction and function registers
	// -----------------------------------------------------------------

	// Reset turns every pin into an input and frees all pins
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			pe_dir_q <= `SGP_RST_PE_DIR;
			pf_dir_q <= `SGP_RST_PF_DIR;
			pg_dir_q <= `SGP_RST_PG_DIR;
			func_q <= `SGP_RST_FUNC;
		end else if (wr_en) begin
			if (wr_strb[0] && wr_idx == `SGP_IDX_PE_DIR) begin
				pe_dir_q <= wr_data[7:0];
			end
			if (wr_strb[0] && wr_idx == `SGP_IDX_PF_DIR) begin
				pf_dir_q <= wr_data[6:0];
			end
			if (wr_strb[0] && wr_idx == `SGP_IDX_PG_DIR) begin
				pg_dir_q <= wr_data[2:0];
			end
			if (wr_idx == `SGP_IDX_FUNC) begin
				// Byte lanes honoured so fields can be set alone
				if (wr_strb[0]) begin
					func_q[7:0] <= wr_data[7:0];
				end
				if (wr_strb[1]) begin
					func_q[15:8] <= wr_data[15:8];
				end
				if (wr_strb[2]) begin
					func_q[22:16] <= wr_data[22:16];
				end
			end
		end
	end

	// -----------------------------------------------------------------
	// Pin ownership
	// -----------------------------------------------------------------
	assign spi_en = func_q[`SGP_FN_SPI_EN];
	assign spi_mst = func_q[`SGP_FN_SPI_MST];
	assign sci_en = func_q[`SGP_FN_SCI_EN];
	assign kbd_en = func_q[`SGP_FN_KBD_LO+2:`SGP_FN_KBD_LO];

	// Clock, data out and data in follow the SPI enable alone
	assign pe_owned[7:5] = {3{spi_en}};
	// Slave select only when enabled as a slave
	assign pe_owned[4] = spi_en & ~spi_mst;
	// Timer A channels 1 and 0
	assign pe_owned[3] = field_on(func_q[`SGP_FN_ELS_E_LO+3:`SGP_FN_ELS_E_LO+2]);
	assign pe_owned[2] = field_on(func_q[`SGP_FN_ELS_E_LO+1:`SGP_FN_ELS_E_LO]);
	// Receive and transmit of the serial interface
	assign pe_owned[1:0] = {2{sci_en}};

	// Slave select is always an input, whatever anyone asks
	assign pe_alt_oe_eff = {pe_alt_oe_i[7:5], 1'b0, pe_alt_oe_i[3:0]};

	// Port F timer channels, one two-bit field per pin
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi = gi + 1) begin : g_pf_own
			assign pf_owned[gi] =
				field_on(func_q[`SGP_FN_ELS_F_LO+2*gi+1:`SGP_FN_ELS_F_LO+2*gi]);
		end
	endgenerate
	// Pin 6 is shared with nothing
	assign pf_owned[6] = 1'b0;

	// -----------------------------------------------------------------
	// Next pin drive
	// -----------------------------------------------------------------

	// Undriven pins show zero so no unwritten latch leaks out
	always @* begin
		pe_oe_d = (pe_owned & pe_alt_oe_eff) | (~pe_owned & pe_dir_q);
		pe_out_d = pe_oe_d & ((pe_owned & pe_alt_out_i) | (~pe_owned & pe_latch_q));
		pf_oe_d = ({1'b0, pf_alt_oe_i} & pf_owned) | (~pf_owned & pf_dir_q);
		pf_out_d = pf_oe_d &
			(({1'b0, pf_alt_out_i} & pf_owned) | (~pf_owned & pf_latch_q));
		// Keypad inputs are never driven
		pg_oe_d = pg_dir_q & ~kbd_en;
		pg_out_d = pg_oe_d & pg_latch_q;
	end

	// Drive registers; reset releases every pin
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			pe_out_q <= 8'h00;
			pe_oe_q <= 8'h00;
			pf_out_q <= 7'h00;
			pf_oe_q <= 7'h00;
			pg_out_q <= 3'h0;
			pg_oe_q <= 3'h0;
		end else begin
			pe_out_q <= pe_out_d;
			pe_oe_q <= pe_oe_d;
			pf_out_q <= pf_out_d;
			pf_oe_q <= pf_oe_d;
			pg_out_q <= pg_out_d;
			pg_oe_q <= pg_oe_d;
		end
	end

	assign pe_pin_o = pe_out_q;
	assign pe_pin_oe_o = pe_oe_q;
	assign pf_pin_o = pf_out_q;
	assign pf_pin_oe_o = pf_oe_q;
	assign pg_pin_o = pg_out_q;
	assign pg_pin_oe_o = pg_oe_q;

	// -----------------------------------------------------------------
	// Toward the peripherals
	// -----------------------------------------------------------------
	assign pe_level_o = pe_sync_q;
	assign pf_level_o = pf_sync_q;
	// Disabled keypad lines read as zero to the keypad logic
	assign keypad_input_pin_o = pg_sync_q & kbd_en;
	assign spi_enable_bit_o = spi_en;
	assign spi_master_select_bit_o = spi_mst;
	assign sci_enable_bit_o = sci_en;
	assign keypad_interrupt_enable_bits_o = kbd_en;

	// -----------------------------------------------------------------
	// Register decode
	// -----------------------------------------------------------------

	// Write hit: unmapped indices are refused with an error
	always @* begin
		case (wr_idx)
			`SGP_IDX_PE_DATA: wr_hit = 1'b1;
			`SGP_IDX_PF_DATA: wr_hit = 1'b1;
			`SGP_IDX_PG_DATA: wr_hit = 1'b1;
			`SGP_IDX_PE_DIR: wr_hit = 1'b1;
			`SGP_IDX_PF_DIR: wr_hit = 1'b1;
			`SGP_IDX_PG_DIR: wr_hit = 1'b1;
			`SGP_IDX_FUNC: wr_hit = 1'b1;
			`SGP_IDX_OWNED: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// Read mux; direction steers the mix even on claimed pins
	always @* begin
		rd_hit = 1'b1;
		rd_data = 32'h00000000;
		case (rd_idx)
			`SGP_IDX_PE_DATA: begin
				rd_data[7:0] = read_mix(pe_dir_q, pe_latch_q, pe_sync_q);
			end
			`SGP_IDX_PF_DATA: begin
				rd_data[7:0] = read_mix({1'b0, pf_dir_q}, {1'b0, pf_latch_q},
					{1'b0, pf_sync_q});
			end
			`SGP_IDX_PG_DATA: begin
				rd_data[7:0] = read_mix({5'h00, pg_dir_q}, {5'h00, pg_latch_q},
					{5'h00, pg_sync_q});
			end
			`SGP_IDX_PE_DIR: begin
				rd_data[7:0] = pe_dir_q;
			end
			`SGP_IDX_PF_DIR: begin
				rd_data[6:0] = pf_dir_q;
			end
			`SGP_IDX_PG_DIR: begin
				rd_data[2:0] = pg_dir_q;
			end
			`SGP_IDX_FUNC: begin
				rd_data[`SGP_FN_W-1:0] = func_q;
			end
			`SGP_IDX_OWNED: begin
				// Read-only view of which pins a peripheral holds
				rd_data[14:0] = {pf_owned, pe_owned};
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

endmodule // sgp_ports

`default_nettype wire

// [verification/sgp_pin_model.sv]
// Board side of one port: resolves each two-way pin.
// Assumes the bench gives the board level for released pins.
`timescale 1ns/1ps
`default_nettype none
module sgp_pin_model #(
	parameter int W = 8
) (
	input wire logic [W-1:0] drv_i,
	input wire logic [W-1:0] oe_i,
	input wire logic [W-1:0] ext_i,
	output logic [W-1:0] level_o
);
	// Device drive wins; a released pin shows the board
	always_comb begin
		for (int b = 0; b < W; b++) begin
			level_o[b] = oe_i[b] ? drv_i[b] : ext_i[b];
		end
	end
endmodule // sgp_pin_model
`default_nettype wire

// [verification/sgp_ports_assertions.sv]
// Checker for the shared ports: ownership, reset, sync and bus timing.
// Bound to sgp_ports; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module sgp_ports_chk (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic s_axi_rvalid_o,
	input wire logic [7:0] pe_pin_i,
	input wire logic [7:0] pe_pin_o,
	input wire logic [7:0] pe_pin_oe_o,
	input wire logic [7:0] pe_alt_out_i,
	input wire logic [7:0] pe_alt_oe_i,
	input wire logic [7:0] pe_level_o,
	input wire logic [6:0] pf_pin_oe_o,
	input wire logic [2:0] pg_pin_i,
	input wire logic [2:0] pg_pin_oe_o,
	input wire logic [2:0] keypad_input_pin_o,
	input wire logic spi_enable_bit_o,
	input wire logic spi_master_select_bit_o,
	input wire logic sci_enable_bit_o,
	input wire logic [2:0] keypad_interrupt_enable_bits_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	// Peripheral requests one cycle back
	logic [7:0] oe_q;
	logic [7:0] out_q;
	always @(posedge core_clk_i) begin
		oe_q <= pe_alt_oe_i;
		out_q <= pe_alt_out_i;
	end
	chk_reset_float: assert property ($fell(sys_rst_i) |->
		pe_pin_oe_o == 8'h00 && pf_pin_oe_o == 7'h00) else $error("pin driven after reset");
	chk_level_sync: assert property (!$past(sys_rst_i) && !$past(sys_rst_i, 2) |->
		pe_level_o == $past(pe_pin_i, 2)) else $error("pin level not two cycles late");
	chk_spi_drive: assert property (!$past(sys_rst_i) && $past(spi_enable_bit_o) |->
		pe_pin_oe_o[7:5] == oe_q[7:5] && pe_pin_o[7:5] == (out_q[7:5] & oe_q[7:5]))
		else $error("spi pins not driven by peripheral");
	chk_slave_input: assert property (!$past(sys_rst_i) && $past(spi_enable_bit_o) &&
		!$past(spi_master_select_bit_o) |-> !pe_pin_oe_o[4]) else $error("slave select driven");
	chk_sci_drive: assert property (!$past(sys_rst_i) && $past(sci_enable_bit_o) |->
		pe_pin_oe_o[1:0] == oe_q[1:0]) else $error("sci pins not driven by peripheral");
	chk_keypad_level: assert property (!$past(sys_rst_i) && !$past(sys_rst_i, 2) |->
		keypad_input_pin_o == ($past(pg_pin_i, 2) & keypad_interrupt_enable_bits_o))
		else $error("keypad level wrong");
	chk_keypad_float: assert property (!$past(sys_rst_i) |->
		(pg_pin_oe_o & $past(keypad_interrupt_enable_bits_o)) == 3'h0) else $error("keypad pin driven");
	chk_write_answer: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
		else $error("write response not retired");
	chk_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read answer late");
endmodule // sgp_ports_chk
bind sgp_ports sgp_ports_chk sgp_ports_chk_inst (.core_clk_i, .sys_rst_i, .s_axi_bvalid_o,
	.s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .pe_pin_i, .pe_pin_o,
	.pe_pin_oe_o, .pe_alt_out_i, .pe_alt_oe_i, .pe_level_o, .pf_pin_oe_o, .pg_pin_i,
	.pg_pin_oe_o, .keypad_input_pin_o, .spi_enable_bit_o, .spi_master_select_bit_o,
	.sci_enable_bit_o, .keypad_interrupt_enable_bits_o);
`default_nettype wire

// [verification/tb.sv]
// Bench for the shared ports: AXI4-Lite tasks and scenario sequence.
// Assumes sgp_ports and its map header; the bench plays CPU and peripherals.
`timescale 1ns/1ps
`default_nettype none
`include "sgp_map.vh"
module tb;
	// ----------------
	// Signals
	// ----------------
	localparam logic [1:0] OK = `SGP_RESP_OKAY;
	logic core_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [11:0] s_axi_awaddr_i = 12'h000;
	logic [11:0] s_axi_araddr_i = 12'h000;
	logic [31:0] s_axi_wdata_i = 32'h0;
	logic [3:0] s_axi_wstrb_i = 4'hf;
	logic s_axi_awvalid_i = 1'b0;
	logic s_axi_wvalid_i = 1'b0;
	logic s_axi_bready_i = 1'b0;
	logic s_axi_arvalid_i = 1'b0;
	logic s_axi_rready_i = 1'b0;
	wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
	wire [31:0] s_axi_rdata_o;
	logic [7:0] pe_alt_out_i = 8'h55;
	logic [7:0] pe_alt_oe_i = 8'h00;
	logic [5:0] pf_alt_out_i = 6'h15;
	logic [5:0] pf_alt_oe_i = 6'h00;
	logic [7:0] pe_ext = 8'h3c;
	logic [6:0] pf_ext = 7'h2a;
	logic [2:0] pg_ext = 3'h5;
	logic [7:0] jm;
	wire [7:0] pe_pin_i, pe_pin_o, pe_pin_oe_o, pe_level_o;
	wire [6:0] pf_pin_i, pf_pin_o, pf_pin_oe_o, pf_level_o;
	wire [2:0] pg_pin_i, pg_pin_o, pg_pin_oe_o, keypad_input_pin_o, keypad_interrupt_enable_bits_o;
	wire spi_enable_bit_o, spi_master_select_bit_o, sci_enable_bit_o;
	int num_errors = 0;
	int check_count = 0;
	// Ownership table: function word, owned E/F, forced-input E, keypad G
	logic [22:0] fn [8] = '{23'h1, 23'h3, 23'h4, 23'h10, 23'hc0, 23'h100, 23'h80000, 23'h700000};
	logic [7:0] eo [8] = '{8'hf0, 8'he0, 8'h03, 8'h04, 8'h08, 8'h00, 8'h00, 8'h00};
	logic [7:0] ein [8] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [6:0] fo [8] = '{7'h0, 7'h0, 7'h0, 7'h0, 7'h0, 7'h01, 7'h20, 7'h0};
	logic [2:0] go [8] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h7};
	// ----------------
	// Instances
	// ----------------
	sgp_ports sgp_ports_inst (.core_clk_i, .sys_rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
		.s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
		.s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
		.s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
		.pe_pin_i, .pe_pin_o, .pe_pin_oe_o, .pf_pin_i, .pf_pin_o, .pf_pin_oe_o, .pg_pin_i,
		.pg_pin_o, .pg_pin_oe_o, .pe_alt_out_i, .pe_alt_oe_i, .pf_alt_out_i, .pf_alt_oe_i,
		.pe_level_o, .pf_level_o, .keypad_input_pin_o, .spi_enable_bit_o,
		.spi_master_select_bit_o, .sci_enable_bit_o, .keypad_interrupt_enable_bits_o);
	sgp_pin_model #(.W(8)) pe_side (.drv_i(pe_pin_o), .oe_i(pe_pin_oe_o), .ext_i(pe_ext),
		.level_o(pe_pin_i));
	sgp_pin_model #(.W(7)) pf_side (.drv_i(pf_pin_o), .oe_i(pf_pin_oe_o), .ext_i(pf_ext),
		.level_o(pf_pin_i));
	sgp_pin_model #(.W(3)) pg_side (.drv_i(pg_pin_o), .oe_i(pg_pin_oe_o), .ext_i(pg_ext),
		.level_o(pg_pin_i));
	always #4 core_clk_i = ~core_clk_i;
	// ----------------
	// Tasks
	// ----------------
	task automatic compare(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("checks=%0d errors=%0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Bounded wait step; a hang ends the run
	task automatic step(inout int n);
		@(posedge core_clk_i);
		n++;
		if (n > 64) begin
			num_errors++;
			conclude();
		end
	endtask
	task automatic hold(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	// Both write channels offered together, each released once taken
	task automatic axi_wr(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge core_clk_i);
		s_axi_awaddr_i <= {idx, 2'b00};
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		do begin
			step(n);
			if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
		end while (!s_axi_bvalid_o);
		s_axi_bready_i <= 1'b0;
		compare(s_axi_bresp_o, er);
	endtask
	task automatic axi_rd(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge core_clk_i);
		s_axi_araddr_i <= {idx, 2'b00};
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do begin
			step(n);
			if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
		end while (!s_axi_rvalid_o);
		s_axi_rready_i <= 1'b0;
		compare(s_axi_rdata_o, exp);
		compare(s_axi_rresp_o, er);
	endtask
	// ----------------
	// Sequence
	// ----------------
	initial begin
		repeat (2) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		axi_rd(`SGP_IDX_PE_DIR, 32'h0, OK);
		axi_wr(`SGP_IDX_PE_DATA, 32'ha5, OK);
		axi_wr(`SGP_IDX_PE_DIR, 32'hff, OK);
		hold(3);
		compare(pe_pin_oe_o, 8'hff);
		compare(pe_pin_o, 8'ha5);
		axi_rd(`SGP_IDX_PE_DATA, 32'ha5, OK);
		axi_wr(`SGP_IDX_PE_DIR, 32'h0f, OK);
		axi_wr(`SGP_IDX_PE_DATA, 32'h77, OK);
		hold(3);
		compare(pe_pin_o, 8'h07);
		axi_rd(`SGP_IDX_PE_DATA, {24'h0, pe_ext[7:4], 4'h7}, OK);
		axi_wr(`SGP_IDX_PE_DIR, 32'hff, OK);
		axi_rd(`SGP_IDX_PE_DATA, 32'h77, OK);
		axi_wr(`SGP_IDX_PF_DATA, 32'h55, OK);
		axi_wr(`SGP_IDX_PF_DIR, 32'h0f, OK);
		axi_wr(`SGP_IDX_PG_DATA, 32'h6, OK);
		axi_wr(`SGP_IDX_PG_DIR, 32'h7, OK);
		hold(3);
		compare(pf_pin_oe_o, 7'h0f);
		compare(pg_pin_o, 3'h6);
		axi_rd(`SGP_IDX_PF_DATA, {25'h0, pf_ext[6:4], 4'h5}, OK);
		// Mid-run reset: direction cleared, latches kept
		@(posedge core_clk_i);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		axi_rd(`SGP_IDX_PE_DIR, 32'h0, OK);
		axi_rd(`SGP_IDX_PF_DIR, 32'h0, OK);
		axi_wr(`SGP_IDX_PF_DIR, 32'h7f, OK);
		axi_wr(`SGP_IDX_PG_DIR, 32'h7, OK);
		axi_rd(`SGP_IDX_PF_DATA, 32'h55, OK);
		axi_rd(`SGP_IDX_PG_DATA, 32'h6, OK);
		axi_wr(`SGP_IDX_PE_DATA, 32'hff, OK);
		axi_wr(`SGP_IDX_PF_DATA, 32'h7f, OK);
		axi_wr(`SGP_IDX_PG_DATA, 32'h7, OK);
		axi_wr(`SGP_IDX_PE_DIR, 32'hff, OK);
		// Each peripheral claim, first idle then driving
		for (int i = 0; i < 8; i++) begin
			axi_wr(`SGP_IDX_FUNC, {9'h0, fn[i]}, OK);
			for (int j = 0; j < 2; j++) begin
				@(posedge core_clk_i);
				pe_alt_oe_i <= j ? 8'hff : 8'h00;
				pf_alt_oe_i <= j ? 6'h3f : 6'h00;
				hold(3);
				jm = j ? 8'hff : 8'h00;
				compare(8'(j ? ~ein[i] : ~eo[i]), pe_pin_oe_o);
				compare(8'((~eo[i] | (eo[i] & 8'h55 & jm)) & ~ein[i]), pe_pin_o);
				compare(7'(j ? 7'h7f : ~fo[i]), pf_pin_oe_o);
				compare(7'(~fo[i] | (fo[i] & 7'h15 & jm[6:0])), pf_pin_o);
				compare(3'(~go[i]), pg_pin_oe_o);
				compare(pg_ext & go[i], keypad_input_pin_o);
				compare(pf_level_o, pf_pin_i);
				compare({spi_enable_bit_o, spi_master_select_bit_o, sci_enable_bit_o,
					keypad_interrupt_enable_bits_o}, {fn[i][0], fn[i][1], fn[i][2], fn[i][22:20]});
			end
			axi_rd(`SGP_IDX_PE_DATA, 32'hff, OK);
			axi_rd(`SGP_IDX_PF_DATA, 32'h7f, OK);
			axi_rd(`SGP_IDX_OWNED, {17'h0, fo[i], eo[i]}, OK);
		end
		axi_wr(10'h3ff, 32'h1, `SGP_RESP_SLVERR);
		axi_rd(10'h3ff, 32'h0, `SGP_RESP_SLVERR);
		conclude();
	end
endmodule // tb
`default_nettype wire
